// *** scs_clock_select.sv ***
// Purpose: system clock source selection, divider and switch control
// Assumes: oscillators are modelled as tick strobes on I_CLK_SYS
// Notes:   outputs are enable strobes for the instruction and peripheral clocks
// Functional notes
// - eight system clock options from fast RC, primary, secondary and low-power RC.
// - fast RC nominally 7.37 MHz, frequency tunable by software setting.
// - divisor bits 10:8 divide fast RC by 2 to 256.
// - primary accepts medium-speed, high-speed crystal, or external clock.
// - secondary oscillator uses a 32.768 kHz crystal on dedicated pins.
// - low-power RC at 32.768 kHz also clocks watchdog and fail monitor.
// - only fast RC and primary may pass the 4x multiplier.
// - at reset source comes from initial select and primary mode fields.
// - erased configuration selects fast RC divided source at reset.
// - configuration fields give twelve clock modes.
// - selected clock divided by two gives instruction and peripheral clock; in the pll modes the code gives an fcy pulse on every fosc pulse.
// - instruction clock supports up to 16 MHz.
// - peripheral clock equals instruction clock unless doze ratio reduces it.
// - fail-safe monitor detects clock loss and falls back to fast RC.
// - source may be switched while running.
// - fixed encodings for initial select and primary mode values.
// - switch request bit starts switch to new select; reads zero when done.
// - clock fail flag set on failure, readable and clearable by software.
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scs_consts.svh"
module scs_clock_select
  import scs_pkg::*;
#(
  parameter logic [2:0] ERASED_SRC = `SCS_SRC_FRCN
)
(
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_ARST_N,
  input  wire logic [2:0]  I_INIT_SRC_SEL,
  input  wire logic [1:0]  I_PRI_MODE_SEL,
  input  wire logic        I_CFG_ERASED,
  input  wire logic        I_FRC_TICK,
  input  wire logic        I_PRI_TICK,
  input  wire logic        I_SEC_TICK,
  input  wire logic        I_LOW_POWER_RC_OSC_TICK,
  input  wire logic        I_WAKE_IRQ,
  input  wire logic [3:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  input  wire logic [3:0]  I_AVS_BYTEENABLE,
  output logic [31:0]      O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  output logic             O_FOSC_EN,
  output logic             O_FCY_EN,
  output logic             O_FP_EN,
  output logic [2:0]       O_CUR_SRC,
  output logic             O_PLL_ON,
  output logic             O_SEC_OSC_EN,
  output logic [`SCS_TUNE_W-1:0] O_FRC_TUNE,
  output logic             O_LOW_POWER_RC_OSC_REF_TICK
);

  typedef struct packed
  {
    scs_state_type state;
    logic          strap_done;
    logic [2:0]    cur_src;
    logic [2:0]    new_src;
    logic [1:0]    pri_mode;
    logic          sw_req;
    logic          sec_en;
    logic          fail_flag;
    logic [15:0]   clk_div;
    logic [`SCS_TUNE_W-1:0] tune;
    logic [7:0]    pre_cnt;
    logic          fosc;
    logic          fcy;
    logic          fp;
    logic          half;
    logic [6:0]    doze_cnt;
    logic [31:0]   rdata;
    logic          rvalid;
  } scs_top_type;

  scs_top_type st_q;
  scs_top_type st_d;

  logic src_tick;
  logic stable;
  logic fail_evt;
  logic wr_acc;
  logic rd_acc;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] frc_div_limit(input logic [2:0] sel);
    frc_div_limit = 8'((9'h002 << sel) - 9'h001);
  endfunction

  function automatic logic uses_pll(input logic [2:0] src);
    uses_pll = (src == `SCS_SRC_FAST_RC_WITH_MULTIPLIER) || (src == `SCS_SRC_PRIPLL);
  endfunction

  function automatic logic pick_tick(input logic [2:0] src, input logic f, input logic p,
                                     input logic s, input logic l);
    if ((src == `SCS_SRC_PRI) || (src == `SCS_SRC_PRIPLL))
    begin
      pick_tick = p;
    end
    else if (src == `SCS_SRC_SEC)
    begin
      pick_tick = s;
    end
    else if (src == `SCS_SRC_LOW_POWER_RC_OSC)
    begin
      pick_tick = l;
    end
    else
    begin
      pick_tick = f;
    end
  endfunction

  assign src_tick = pick_tick(st_q.new_src, I_FRC_TICK, I_PRI_TICK, I_SEC_TICK, I_LOW_POWER_RC_OSC_TICK);
  assign wr_acc   = I_AVS_WRITE && !I_AVS_READ;
  assign rd_acc   = I_AVS_READ && !st_q.rvalid;

  // ---------------------------------------------------------------------------
  // sub blocks
  // ---------------------------------------------------------------------------
  scs_stable_cnt #(
    .LIMIT (`SCS_STABLE_CYC)
  ) u_stable (
    .i_clk    (I_CLK_SYS),
    .i_arst_n (I_ARST_N),
    .i_clear  (st_q.state != SCS_WAIT),
    .i_tick   (src_tick),
    .o_done   (stable)
  );

  scs_fail_mon #(
    .WINDOW (`SCS_FAIL_CYC)
  ) u_mon (
    .i_clk      (I_CLK_SYS),
    .i_arst_n   (I_ARST_N),
    .i_enable   (st_q.strap_done && (st_q.cur_src != `SCS_SRC_FRC)),
    .i_ref_tick (I_LOW_POWER_RC_OSC_TICK),
    .i_src_tick (pick_tick(st_q.cur_src, I_FRC_TICK, I_PRI_TICK, I_SEC_TICK, I_LOW_POWER_RC_OSC_TICK)),
    .o_fail     (fail_evt)
  );

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic       cur_tick;
    logic       base;
    logic [7:0] lim;
    logic [6:0] doze_lim;
    cur_tick = pick_tick(st_q.cur_src, I_FRC_TICK, I_PRI_TICK, I_SEC_TICK, I_LOW_POWER_RC_OSC_TICK);
    base     = 1'b0;
    lim      = 8'h00;
    doze_lim = 7'((8'h01 << st_q.clk_div[`SCS_DIV_DOZE_LO +: 3]) - 8'h01);
    st_d     = st_q;
    st_d.fosc   = 1'b0;
    st_d.fcy    = 1'b0;
    st_d.fp     = 1'b0;
    st_d.rvalid = 1'b0;

    // strap capture after reset release
    if (!st_q.strap_done)
    begin
      st_d.strap_done = 1'b1;
      st_d.cur_src    = I_CFG_ERASED ? ERASED_SRC : I_INIT_SRC_SEL;
      st_d.new_src    = I_CFG_ERASED ? ERASED_SRC : I_INIT_SRC_SEL;
      st_d.pri_mode   = I_PRI_MODE_SEL;
    end

    // prescaler for fast RC divide modes
    if (cur_tick)
    begin
      if (st_q.cur_src == `SCS_SRC_FRCN)
      begin
        lim = frc_div_limit(st_q.clk_div[`SCS_DIV_FRC_LO +: 3]);
      end
      else if (st_q.cur_src == `SCS_SRC_FRC16)
      begin
        lim = `SCS_FRC16_LIM;
      end
      if (st_q.pre_cnt >= lim)
      begin
        st_d.pre_cnt = 8'h00;
        base = 1'b1;
      end
      else
      begin
        st_d.pre_cnt = st_q.pre_cnt + 8'h01;
      end
    end

    // pll doubles fcy: one tick becomes a fosc pulse and an fcy pulse, no halving
    if (base && st_q.strap_done && (st_q.state != SCS_SWAP) && !fail_evt)
    begin
      st_d.fosc = 1'b1;
      st_d.half = ~st_q.half;
      if (uses_pll(st_q.cur_src))
      begin
        st_d.half = st_q.half;
        st_d.fcy  = 1'b1;
      end
      else
      begin
        st_d.fcy = st_q.half;
      end
    end

    // doze divider for peripheral clock
    if (st_d.fcy)
    begin
      if (!st_q.clk_div[`SCS_DIV_DOZEN] || (st_q.doze_cnt >= doze_lim))
      begin
        st_d.fp       = 1'b1;
        st_d.doze_cnt = 7'h00;
      end
      else
      begin
        st_d.doze_cnt = st_q.doze_cnt + 7'h01;
      end
    end
    if (I_WAKE_IRQ && st_q.clk_div[`SCS_DIV_ROI])
    begin
      st_d.clk_div[`SCS_DIV_DOZEN] = 1'b0;
    end

    // register writes
    if (wr_acc && st_q.strap_done)
    begin
      if (I_AVS_ADDRESS == `SCS_OFS_OSC_CTRL)
      begin
        if (I_AVS_BYTEENABLE[0])
        begin
          st_d.sec_en = I_AVS_WRITEDATA[`SCS_CTL_SECEN];
          if (!I_AVS_WRITEDATA[`SCS_CTL_FAIL])
          begin
            st_d.fail_flag = 1'b0;
          end
          if (I_AVS_WRITEDATA[`SCS_CTL_SWREQ] && (st_q.state == SCS_IDLE))
          begin
            st_d.sw_req = 1'b1;
          end
        end
        if (I_AVS_BYTEENABLE[1] && (st_q.state == SCS_IDLE))
        begin
          st_d.new_src = I_AVS_WRITEDATA[`SCS_CTL_NEW_LO +: 3];
        end
      end
      else if (I_AVS_ADDRESS == `SCS_OFS_CLK_DIV)
      begin
        if (I_AVS_BYTEENABLE[1])
        begin
          st_d.clk_div[15:8] = I_AVS_WRITEDATA[15:8];
        end
      end
      else if (I_AVS_ADDRESS == `SCS_OFS_TUNE)
      begin
        if (I_AVS_BYTEENABLE[0])
        begin
          st_d.tune = I_AVS_WRITEDATA[`SCS_TUNE_W-1:0];
        end
      end
    end

    // switch sequencer
    case (st_q.state)
      SCS_IDLE:
      begin
        if (st_q.sw_req)
        begin
          st_d.state = SCS_WAIT;
        end
      end
      SCS_WAIT:
      begin
        if (stable)
        begin
          st_d.state = SCS_SWAP;
        end
      end
      SCS_SWAP:
      begin
        st_d.cur_src = st_q.new_src;
        st_d.pre_cnt = 8'h00;
        st_d.half    = 1'b0;
        st_d.sw_req  = 1'b0;
        st_d.state   = SCS_IDLE;
      end
      default:
      begin
        st_d.state = SCS_IDLE;
      end
    endcase

    // fail-safe fallback, set wins over clear
    if (fail_evt)
    begin
      st_d.fail_flag = 1'b1;
      st_d.cur_src   = `SCS_SRC_FRC;
      st_d.new_src   = `SCS_SRC_FRC;
      st_d.sw_req    = 1'b0;
      st_d.state     = SCS_IDLE;
    end

    // register reads
    if (rd_acc)
    begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = 32'h0000_0000;
      if (I_AVS_ADDRESS == `SCS_OFS_OSC_CTRL)
      begin
        st_d.rdata[`SCS_CTL_CUR_LO +: 3] = st_q.cur_src;
        st_d.rdata[`SCS_CTL_NEW_LO +: 3] = st_q.new_src;
        st_d.rdata[`SCS_CTL_FAIL]        = st_q.fail_flag;
        st_d.rdata[`SCS_CTL_SECEN]       = st_q.sec_en;
        st_d.rdata[`SCS_CTL_SWREQ]       = st_q.sw_req;
      end
      else if (I_AVS_ADDRESS == `SCS_OFS_CLK_DIV)
      begin
        st_d.rdata[15:0] = st_q.clk_div;
      end
      else if (I_AVS_ADDRESS == `SCS_OFS_TUNE)
      begin
        st_d.rdata[`SCS_TUNE_W-1:0] = st_q.tune;
      end
      else if (I_AVS_ADDRESS == `SCS_OFS_STATUS)
      begin
        st_d.rdata[`SCS_STS_STATE_LO +: 2] = st_q.state;
        st_d.rdata[`SCS_STS_PMODE_LO +: 2] = st_q.pri_mode;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      st_q         <= '0;
      st_q.state   <= SCS_IDLE;
      st_q.clk_div <= `SCS_DIV_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign O_AVS_WAITREQUEST = I_AVS_READ && !st_q.rvalid;
  assign O_AVS_READDATA    = st_q.rdata;
  assign O_FOSC_EN         = st_q.fosc;
  assign O_FCY_EN          = st_q.fcy;
  assign O_FP_EN           = st_q.fp;
  assign O_CUR_SRC         = st_q.cur_src;
  assign O_PLL_ON          = uses_pll(st_q.cur_src);
  assign O_SEC_OSC_EN      = st_q.sec_en || (st_q.cur_src == `SCS_SRC_SEC);
  assign O_FRC_TUNE        = st_q.tune;
  assign O_LOW_POWER_RC_OSC_REF_TICK   = I_LOW_POWER_RC_OSC_TICK;

endmodule
`default_nettype wire

// *** scs_clock_select_sva.sv ***
// Purpose: port checker for the clock select block
// Assumes: bound to the top module
// Notes:   one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "scs_consts.svh"
module scs_clock_select_chk
  import scs_pkg::*;
(
  input wire logic                   I_CLK_SYS,
  input wire logic                   I_ARST_N,
  input wire logic                   I_LOW_POWER_RC_OSC_TICK,
  input wire logic [3:0]             I_AVS_ADDRESS,
  input wire logic                   I_AVS_READ,
  input wire logic                   I_AVS_WRITE,
  input wire logic [31:0]            I_AVS_WRITEDATA,
  input wire logic [3:0]             I_AVS_BYTEENABLE,
  input wire logic                   O_AVS_WAITREQUEST,
  input wire logic                   O_FOSC_EN,
  input wire logic                   O_FCY_EN,
  input wire logic                   O_FP_EN,
  input wire logic [2:0]             O_CUR_SRC,
  input wire logic                   O_PLL_ON,
  input wire logic                   O_SEC_OSC_EN,
  input wire logic [`SCS_TUNE_W-1:0] O_FRC_TUNE,
  input wire logic                   O_LOW_POWER_RC_OSC_REF_TICK
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_ARST_N);

  a_pll_flag: assert property (O_PLL_ON == (O_CUR_SRC == 3'h1 || O_CUR_SRC == 3'h3))
    else $error("pll flag disagrees with source");
  a_low_power_rc_osc_ref: assert property (O_LOW_POWER_RC_OSC_REF_TICK == I_LOW_POWER_RC_OSC_TICK)
    else $error("reference tick not passed on");
  a_sec_on: assert property (O_CUR_SRC == 3'h4 |-> O_SEC_OSC_EN)
    else $error("secondary running while disabled");
  a_fosc_gap: assert property (O_FOSC_EN |=> !O_FOSC_EN)
    else $error("runt oscillator pulse");
  a_fcy_half: assert property (O_FCY_EN && !O_PLL_ON |=> !O_FCY_EN)
    else $error("instruction clock not halved");
  a_fp_in_fcy: assert property (O_FP_EN |-> O_FCY_EN)
    else $error("peripheral pulse without instruction pulse");
  a_swap_quiet: assert property ($changed(O_CUR_SRC) |-> !O_FOSC_EN)
    else $error("source changed next to a clock pulse");
  a_write_now: assert property (I_AVS_WRITE |-> !O_AVS_WAITREQUEST)
    else $error("write stalled");
  a_read_wait: assert property ($rose(I_AVS_READ) |-> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST)
    else $error("read answer not after one wait");
  a_tune_write: assert property (I_AVS_WRITE && I_AVS_ADDRESS == 4'h8 && I_AVS_BYTEENABLE[0]
    |=> O_FRC_TUNE == $past(I_AVS_WRITEDATA[5:0]))
    else $error("tune value not taken");
endmodule
bind scs_clock_select scs_clock_select_chk u_scs_clock_select_chk (.I_CLK_SYS, .I_ARST_N,
  .I_LOW_POWER_RC_OSC_TICK, .I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE, .I_AVS_WRITEDATA,
  .I_AVS_BYTEENABLE, .O_AVS_WAITREQUEST, .O_FOSC_EN, .O_FCY_EN, .O_FP_EN, .O_CUR_SRC,
  .O_PLL_ON, .O_SEC_OSC_EN, .O_FRC_TUNE, .O_LOW_POWER_RC_OSC_REF_TICK);
`default_nettype wire

// *** scs_consts.svh ***
// Purpose: constants for the system clock source select block
// Assumes: included by bare name
// Notes:   register offsets are byte addresses on a 32-bit Avalon-MM bus
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// -----------------------------------------------------------------------------
// register map
// -----------------------------------------------------------------------------
`define SCS_ADDR_W          4
`define SCS_OFS_OSC_CTRL    4'h0
`define SCS_OFS_CLK_DIV     4'h4
`define SCS_OFS_TUNE        4'h8
`define SCS_OFS_STATUS      4'hC

// -----------------------------------------------------------------------------
// control register fields
// -----------------------------------------------------------------------------
`define SCS_CTL_SWREQ       0
`define SCS_CTL_SECEN       1
`define SCS_CTL_FAIL        3
`define SCS_CTL_NEW_LO      8
`define SCS_CTL_CUR_LO      12

// -----------------------------------------------------------------------------
// divisor, tune and status register fields, divisor reset value
// -----------------------------------------------------------------------------
`define SCS_DIV_FRC_LO      8
`define SCS_DIV_DOZEN       11
`define SCS_DIV_DOZE_LO     12
`define SCS_DIV_ROI         15
`define SCS_DIV_RST         16'h3000
`define SCS_TUNE_W          6
`define SCS_STS_STATE_LO    0
`define SCS_STS_PMODE_LO    4

// -----------------------------------------------------------------------------
// source encodings
// -----------------------------------------------------------------------------
`define SCS_SRC_FRC         3'h0
`define SCS_SRC_FAST_RC_WITH_MULTIPLIER      3'h1
`define SCS_SRC_PRI         3'h2
`define SCS_SRC_PRIPLL      3'h3
`define SCS_SRC_SEC         3'h4
`define SCS_SRC_LOW_POWER_RC_OSC        3'h5
`define SCS_SRC_FRC16       3'h6
`define SCS_SRC_FRCN        3'h7
`define SCS_PMODE_EXT       2'h0
`define SCS_PMODE_MED       2'h1
`define SCS_PMODE_HIGH      2'h2

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define SCS_PLL_MULT        4
`define SCS_STABLE_CYC      8'h10
`define SCS_FRC16_LIM       8'h0F
`define SCS_FAIL_CYC        8'h40
`define SCS_FRC_KHZ         7370
`define SCS_LOW_POWER_RC_OSC_HZ         32768
`define SCS_FCY_MAX_MHZ     16

`endif

// *** scs_fail_mon.sv ***
// Purpose: fail-safe monitor for the running source
// Assumes: tick strobes synchronous to I_CLK_SYS
// Notes:   counts reference ticks with no source tick between them
`timescale 1ns/1ps
`default_nettype none
module scs_fail_mon
  import scs_pkg::*;
#(
  parameter logic [7:0] WINDOW = 8'h40
)
(
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_enable,
  input  wire logic i_ref_tick,
  input  wire logic i_src_tick,
  output var  logic o_fail
);

  typedef struct packed
  {
    logic [7:0] gap;
    logic       fail;
  } scs_mon_type;

  scs_mon_type st_q;
  scs_mon_type st_d;

  always_comb
  begin
    st_d      = st_q;
    st_d.fail = 1'b0;
    if (!i_enable || i_src_tick)
    begin
      st_d.gap = 8'h00;
    end
    else if (i_ref_tick)
    begin
      if (st_q.gap == WINDOW)
      begin
        st_d.fail = 1'b1;
        st_d.gap  = 8'h00;
      end
      else
      begin
        st_d.gap = st_q.gap + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign o_fail = st_q.fail;

endmodule
`default_nettype wire

// *** scs_osc_model.sv ***
// Purpose: oscillator tick source facing the clock select block
// Assumes: one-cycle ticks on the system clock
// Notes:   primary can be stopped to provoke a clock loss
`timescale 1ns/1ps
`default_nettype none
module scs_osc_model
(
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_pri_stop,
  output var  logic o_frc,
  output var  logic o_pri,
  output var  logic o_sec,
  output var  logic o_low_power_rc_osc
);
  int c;

  // ---------------------------------------------------------------
  // free counter, coprime periods keep sources unrelated
  // ---------------------------------------------------------------
  always @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
      c <= 0;
    else
      c <= c + 1;

  assign o_frc  = (c % 3) == 2;
  assign o_pri  = !i_pri_stop && (c % 4) == 1;
  assign o_sec  = (c % 5) == 3;
  assign o_low_power_rc_osc = (c % 7) == 4;
endmodule
`default_nettype wire

// *** scs_pkg.sv ***
// Purpose: types for the system clock source select block
// Assumes: none
// Notes:   state enum of the switch sequencer
package scs_pkg;

  typedef enum logic [1:0]
  {
    SCS_IDLE   = 2'b00,
    SCS_WAIT   = 2'b01,
    SCS_SWAP   = 2'b10
  } scs_state_type;

endpackage

// *** scs_stable_cnt.sv ***
// Purpose: counts consecutive ticks of a clock-present strobe
// Assumes: strobes synchronous to I_CLK_SYS
// Notes:   o_done rises once the count reaches LIMIT
`timescale 1ns/1ps
`default_nettype none
module scs_stable_cnt
  import scs_pkg::*;
#(
  parameter logic [7:0] LIMIT = 8'h10
)
(
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_clear,
  input  wire logic i_tick,
  output var  logic o_done
);

  typedef struct packed
  {
    logic [7:0] cnt;
  } scs_cnt_type;

  scs_cnt_type st_q;
  scs_cnt_type st_d;

  always_comb
  begin
    st_d = st_q;
    if (i_clear)
    begin
      st_d.cnt = 8'h00;
    end
    else if (i_tick && (st_q.cnt != LIMIT))
    begin
      st_d.cnt = st_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign o_done = (st_q.cnt == LIMIT);

endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the clock select block
// Assumes: ticks from the oscillator model
// Notes:   fast RC tick every 3 cycles, primary every 4
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import scs_pkg::*;
;
  logic        clk, arst_n, erased, pri_stop, rd, wr, wake;
  logic [2:0]  init_sel, cur;
  logic [1:0]  pmode;
  logic [3:0]  addr, be;
  logic [31:0] wdata, rdata;
  logic [5:0]  tune;
  wire         fast_rc_osc, pri, sec, low_power_rc_osc;
  logic        waitreq, fosc, fcy, fp, pll, secen, lref;
  int          bad_count, n_compared;

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  scs_osc_model u_scs_osc_model (.i_clk(clk), .i_arst_n(arst_n), .i_pri_stop(pri_stop),
    .o_frc(fast_rc_osc), .o_pri(pri), .o_sec(sec), .o_low_power_rc_osc(low_power_rc_osc));

  scs_clock_select u_scs_clock_select (.I_CLK_SYS(clk), .I_ARST_N(arst_n),
    .I_INIT_SRC_SEL(init_sel), .I_PRI_MODE_SEL(pmode), .I_CFG_ERASED(erased),
    .I_FRC_TICK(fast_rc_osc), .I_PRI_TICK(pri), .I_SEC_TICK(sec), .I_LOW_POWER_RC_OSC_TICK(low_power_rc_osc),
    .I_WAKE_IRQ(wake), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(waitreq), .O_FOSC_EN(fosc), .O_FCY_EN(fcy), .O_FP_EN(fp),
    .O_CUR_SRC(cur), .O_PLL_ON(pll), .O_SEC_OSC_EN(secen), .O_FRC_TUNE(tune),
    .O_LOW_POWER_RC_OSC_REF_TICK(lref));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int n;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n == 50)
      bad_count++;
  endtask

  task automatic wrt(input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] q;
    bus(1'b1, a, d, b, q);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
    chk(q & m, e);
  endtask

  task automatic poll(input logic [31:0] m, input logic [31:0] e, output logic [31:0] q);
    for (int i = 0; i < 300; i++)
    begin
      bus(1'b0, 4'h0, 32'h0000_0000, 4'hF, q);
      if ((q & m) === e)
        break;
    end
  endtask

  task automatic do_reset(input logic [2:0] s, input logic [1:0] p, input logic e);
    @(posedge clk);
    arst_n <= 1'b0;
    init_sel <= s;
    pmode <= p;
    erased <= e;
    pri_stop <= 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  function automatic logic pick(input int k);
    return (k == 0) ? fosc : ((k == 1) ? fcy : fp);
  endfunction

  task automatic gap(input int k, output int n);
    for (int j = 0; j < 3; j++)
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end while (pick(k) !== 1'b1 && n < 2000);
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_straps();
    int n;
    int per [8] = '{3, 3, 4, 4, 5, 7, 48, 6};
    for (int s = 0; s < 8; s++)
    begin
      do_reset(s[2:0], 2'(s % 3), 1'b0);
      rdc(4'h0, 32'h0000_7000, s << 12);
      rdc(4'hC, 32'h0000_0030, (s % 3) << 4);
      chk(pll, s == 1 || s == 3);
      gap(0, n);
      chk(n, per[s]);
      gap(1, n);
      chk(n, (s == 1 || s == 3) ? per[s] : 2 * per[s]);
    end
    do_reset(3'h0, 2'h1, 1'b1);
    chk(cur, 3'h7);
    $display("test straps done");
  endtask

  task automatic t_regs();
    do_reset(3'h7, 2'h0, 1'b0);
    rdc(4'h4, 32'hFFFF_FFFF, 32'h0000_3000);
    do
    begin
      @(posedge clk);
    end while (low_power_rc_osc !== 1'b1);
    chk(lref, 1'b1);
    wrt(4'h8, 32'h0000_002A, 4'h1);
    rdc(4'h8, 32'h0000_003F, 32'h0000_002A);
    chk(tune, 6'h2A);
    rdc(4'h6, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test registers done");
  endtask

  task automatic t_divide();
    int n;
    for (int d = 0; d < 3; d++)
    begin
      wrt(4'h4, d << 8, 4'h2);
      gap(0, n);
      chk(n, 3 << (d + 1));
      gap(1, n);
      chk(n, 6 << (d + 1));
      gap(2, n);
      chk(n, 6 << (d + 1));
    end
    $display("test divide done");
  endtask

  task automatic t_doze();
    int n;
    wrt(4'h4, 32'h0000_9800, 4'h2);
    gap(2, n);
    chk(n, 24);
    @(posedge clk);
    wake <= 1'b1;
    repeat (4) @(posedge clk);
    wake <= 1'b0;
    rdc(4'h4, 32'h0000_0800, 32'h0000_0000);
    gap(2, n);
    chk(n, 12);
    $display("test doze done");
  endtask

  task automatic t_switch();
    logic [31:0] q;
    wrt(4'h0, 32'h0000_0201, 4'h3);
    rdc(4'h0, 32'h0000_0001, 32'h0000_0001);
    wrt(4'h0, 32'h0000_0501, 4'h3);
    poll(32'h0000_0001, 32'h0000_0000, q);
    chk(q & 32'h0000_7001, 32'h0000_2000);
    chk(cur, 3'h2);
    wrt(4'h0, 32'h0000_0002, 4'h1);
    repeat (2) @(posedge clk);
    chk(secen, 1'b1);
    wrt(4'h0, 32'h0000_0000, 4'h1);
    repeat (2) @(posedge clk);
    chk(secen, 1'b0);
    $display("test switch done");
  endtask

  task automatic t_fail();
    logic [31:0] q;
    @(posedge clk);
    pri_stop <= 1'b1;
    poll(32'h0000_0008, 32'h0000_0008, q);
    chk(q & 32'h0000_7008, 32'h0000_0008);
    chk(cur, 3'h0);
    wrt(4'h0, 32'h0000_0000, 4'h1);
    rdc(4'h0, 32'h0000_0008, 32'h0000_0000);
    $display("test fail done");
  endtask

  initial
  begin
    #300000;
    bad_count++;
    end_of_test();
  end

  initial
  begin
    arst_n = 1'b0;
    erased = 1'b0;
    pri_stop = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    wake = 1'b0;
    init_sel = 3'h0;
    pmode = 2'h0;
    addr = 4'h0;
    be = 4'h0;
    wdata = 32'h0000_0000;
    bad_count = 0;
    n_compared = 0;
    t_straps();
    t_regs();
    t_divide();
    t_doze();
    t_switch();
    t_fail();
    end_of_test();
  end
endmodule
`default_nettype wire
